// ### common/anps_pkg.sv
// Purpose: Shared constants and types of the partner ability status block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one word per register
// Notes:   Register index times four gives the byte address

package anps_pkg;

    // ****************************************************************
    // Bus and register geometry
    // ****************************************************************
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 16;
    localparam int          IDX_W         = ADDR_W - 2;
    localparam logic [5:0]  IDX_LOCAL_ADV = 6'h04;
    localparam logic [5:0]  IDX_PARTNER   = 6'h05;
    localparam logic [5:0]  IDX_EXPANSION = 6'h06;
    localparam logic [5:0]  IDX_CONTROL   = 6'h10;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int          ADV_PAUSE_BIT   = 10;
    localparam int          ADV_TECH_LSB    = 5;
    localparam int          ADV_TECH_MSB    = 8;
    localparam int          PA_ACK_BIT      = 14;
    localparam int          PA_NP_BIT       = 15;
    localparam int          EXP_BASE_PAGE   = 5;
    localparam int          EXP_PD_FAULT    = 4;
    localparam int          EXP_LP_NP_ABLE  = 3;
    localparam int          EXP_NP_ABLE     = 2;
    localparam int          EXP_PAGE_RX     = 1;
    localparam int          EXP_LP_AN_ABLE  = 0;
    localparam int          EXP_RSVD_LSB    = 6;
    localparam int          CTRL_TX_DISABLE = 13;
    localparam int          CTRL_ALT_NP     = 1;

    // ****************************************************************
    // Values
    // ****************************************************************
    localparam logic        LOCAL_NP_ABLE = 1'b1;
    localparam logic [4:0]  SEL_IEEE8023  = 5'h01;
    localparam logic [4:0]  SEL_IEEE8029  = 5'h02;
    localparam logic [4:0]  SEL_RSVD_LO   = 5'h00;
    localparam logic [4:0]  SEL_RSVD_HI   = 5'h1f;
    localparam logic [1:0]  SYNC_FILL     = 2'h3;
    localparam logic [15:0] REG_ZERO      = 16'h0000;
    localparam logic [31:0] WORD_ZERO     = 32'h00000000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic        base_page_rx;
        logic        next_page_rx;
        logic [15:0] code_word;
        logic        base_page_var;
        logic        pd_fault;
        logic        partner_np_able;
        logic        partner_an_able;
        logic        mr_page_rx;
    } anps_link_s;

    typedef struct packed {
        logic       pause;
        logic [3:0] tech;
    } anps_adv_s;

    typedef struct packed {
        logic [4:0]  pin_s1;
        logic [4:0]  pin_s2;
        logic [4:0]  pin_s3;
        logic [1:0]  fill_cnt;
        logic        loaded;
        anps_adv_s   adv;
        logic        alt_np;
        logic        tx_disable;
        logic        ack;
        logic [31:0] rdata;
        logic [15:0] ability;
        logic        base_page;
        logic        pd_fault;
        logic        page_rx;
    } anps_state_s;

endpackage

// ### src/anps_status.sv
// Purpose: Partner ability and negotiation expansion status registers
// Assumes: Negotiation engine on CLOCK_I; strap pins asynchronous
// Notes:   Waitrequest low on the second cycle of every access
//
// The Avalon-MM register port is this design's own decision.

`timescale 1ns/100ps

module anps_status
(
    input  wire logic                CLOCK_I,
    input  wire logic                RSTN_I,
    input  wire logic [7:0]          AVS_ADDRESS_I,
    input  wire logic                AVS_READ_I,
    input  wire logic                AVS_WRITE_I,
    input  wire logic [31:0]         AVS_WRITEDATA_I,
    input  wire logic [3:0]          AVS_BYTEENABLE_I,
    output logic      [31:0]         AVS_READDATA_O,
    output logic                     AVS_WAITREQUEST_O,
    input  wire anps_pkg::anps_link_s LINK_I,
    input  wire logic                PAUSE_CFG_PIN_I,
    input  wire logic [3:0]          LED_CONFIG_PINS_I,
    output anps_pkg::anps_adv_s      ADV_O,
    output logic                     ALT_NP_O,
    output logic                     TX_DISABLE_O
);
    import anps_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Byte enables widened to a bit mask
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Expansion word from latched and live flags
    function automatic logic [15:0] exp_word(input anps_state_s s, input anps_link_s l);
        logic [15:0] w;
        w                 = REG_ZERO;
        w[EXP_BASE_PAGE]  = s.base_page;
        w[EXP_PD_FAULT]   = s.pd_fault;
        w[EXP_LP_NP_ABLE] = l.partner_np_able;
        w[EXP_NP_ABLE]    = LOCAL_NP_ABLE;
        w[EXP_PAGE_RX]    = s.page_rx;
        w[EXP_LP_AN_ABLE] = l.partner_an_able;
        exp_word          = w;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    anps_state_s            st;
    anps_state_s            next_st;
    logic                   req;
    logic                   accept;
    logic [5:0]             idx;
    logic                   exp_read;
    logic                   page_set;
    logic                   alt_clear;
    logic [15:0]            mask;
    logic [15:0]            adv_word;
    logic [15:0]            ctrl_word;
    logic [15:0]            adv_new;
    logic [15:0]            ctrl_new;
    logic [15:0]            rd_clear;

    // Bus request decode
    assign req      = AVS_READ_I | AVS_WRITE_I;
    assign accept   = req & st.ack;
    assign idx      = AVS_ADDRESS_I[ADDR_W-1:2];
    assign exp_read = accept & AVS_READ_I & (idx == IDX_EXPANSION);
    assign mask     = lane_mask(AVS_BYTEENABLE_I);
    assign page_set = LINK_I.base_page_rx | LINK_I.next_page_rx;
    assign alt_clear = st.alt_np & (~LINK_I.mr_page_rx | st.tx_disable);

    // Written lanes merged into the current images
    assign adv_new   = (adv_word & ~mask) | (AVS_WRITEDATA_I[REG_W-1:0] & mask);
    assign ctrl_new  = (ctrl_word & ~mask) | (AVS_WRITEDATA_I[REG_W-1:0] & mask);

    // A read clears only the latched bits it actually reported
    assign rd_clear  = exp_read ? st.rdata[REG_W-1:0] : REG_ZERO;

    // Readable images of own registers
    always_comb
    begin
        adv_word                            = REG_ZERO;
        adv_word[ADV_PAUSE_BIT]             = st.adv.pause;
        adv_word[ADV_TECH_MSB:ADV_TECH_LSB] = st.adv.tech;
        ctrl_word                           = REG_ZERO;
        ctrl_word[CTRL_TX_DISABLE]          = st.tx_disable;
        ctrl_word[CTRL_ALT_NP]              = st.alt_np;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;

        // Strap pins through three stages
        next_st.pin_s1 = {PAUSE_CFG_PIN_I, LED_CONFIG_PINS_I};
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_s3 = st.pin_s2;

        // Strap defaults caught once after release
        if (!st.loaded)
        begin
            if (st.fill_cnt != SYNC_FILL)
            begin
                next_st.fill_cnt = st.fill_cnt + 2'h1;
            end
            else if (st.pin_s2 == st.pin_s3)
            begin
                next_st.loaded    = 1'b1;
                next_st.adv.pause = st.pin_s3[4];
                next_st.adv.tech  = st.pin_s3[3:0];
            end
        end

        // Handshake: wait one cycle, then accept
        next_st.ack = req & ~st.ack;

        // Read data captured in the waiting cycle
        if (req & ~st.ack & AVS_READ_I)
        begin
            case (idx)
                IDX_LOCAL_ADV: next_st.rdata = {REG_ZERO, adv_word};
                IDX_PARTNER:   next_st.rdata = {REG_ZERO, st.ability};
                IDX_EXPANSION: next_st.rdata = {REG_ZERO, exp_word(st, LINK_I)};
                IDX_CONTROL:   next_st.rdata = {REG_ZERO, ctrl_word};
                default:       next_st.rdata = WORD_ZERO;
            endcase
        end

        // Software writes at the accepting edge
        if (accept & AVS_WRITE_I)
        begin
            case (idx)
                IDX_LOCAL_ADV:
                begin
                    next_st.adv.pause = adv_new[ADV_PAUSE_BIT];
                    next_st.adv.tech  = adv_new[ADV_TECH_MSB:ADV_TECH_LSB];
                end
                IDX_CONTROL:
                begin
                    next_st.tx_disable = ctrl_new[CTRL_TX_DISABLE];
                    next_st.alt_np     = ctrl_new[CTRL_ALT_NP];
                end
                default:
                begin
                    next_st.alt_np = st.alt_np;
                end
            endcase
        end

        // Partner word stored whole on a complete base page
        if (LINK_I.base_page_rx)
        begin
            next_st.ability = LINK_I.code_word;
        end

        // Latching flags: set wins, unreported events survive the read
        next_st.base_page = (st.base_page & ~rd_clear[EXP_BASE_PAGE]) | (LINK_I.base_page_var & st.alt_np);
        next_st.pd_fault  = (st.pd_fault & ~rd_clear[EXP_PD_FAULT]) | LINK_I.pd_fault;
        next_st.page_rx   = (st.page_rx & ~(rd_clear[EXP_PAGE_RX] | alt_clear)) | page_set;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs
    assign AVS_WAITREQUEST_O = req & ~st.ack;
    assign AVS_READDATA_O    = st.rdata;
    assign ADV_O             = st.adv;
    assign ALT_NP_O          = st.alt_np;
    assign TX_DISABLE_O      = st.tx_disable;

    // ****************************************************************
    // Checks
    // ****************************************************************

    // Expansion read, waiting then accepted
    sequence s_exp_wait;
        AVS_READ_I && !st.ack && (idx == IDX_EXPANSION);
    endsequence

    sequence s_exp_accept;
        AVS_READ_I && st.ack && !AVS_WAITREQUEST_O && (idx == IDX_EXPANSION);
    endsequence

    // Partner read, waiting then accepted
    sequence s_part_wait;
        AVS_READ_I && !st.ack && (idx == IDX_PARTNER);
    endsequence

    sequence s_read_accept;
        AVS_READ_I && st.ack;
    endsequence

    property p_pause_default;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $rose(st.loaded) |-> (ADV_O.pause == $past(st.pin_s3[4]));
    endproperty
    a_pause_default: assert property (p_pause_default)
        else $error("pause default not taken from strap");

    property p_tech_default;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $rose(st.loaded) |-> (ADV_O.tech == $past(st.pin_s3[3:0]));
    endproperty
    a_tech_default: assert property (p_tech_default)
        else $error("technology defaults not taken from straps");

    property p_ability_load;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        LINK_I.base_page_rx |=> (st.ability == $past(LINK_I.code_word));
    endproperty
    a_ability_load: assert property (p_ability_load)
        else $error("partner word not stored on base page");

    property p_ability_hold;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        !LINK_I.base_page_rx |=> $stable(st.ability);
    endproperty
    a_ability_hold: assert property (p_ability_hold)
        else $error("partner word changed without base page");

    property p_ack_read;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_part_wait ##1 s_read_accept |-> (AVS_READDATA_O[PA_ACK_BIT] == $past(st.ability[PA_ACK_BIT]));
    endproperty
    a_ack_read: assert property (p_ack_read)
        else $error("acknowledge bit read wrong");

    property p_pd_fault_set;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        LINK_I.pd_fault |=> st.pd_fault;
    endproperty
    a_pd_fault_set: assert property (p_pd_fault_set)
        else $error("parallel fault not latched");

    property p_pd_fault_hold;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (st.pd_fault && !exp_read) |=> st.pd_fault;
    endproperty
    a_pd_fault_hold: assert property (p_pd_fault_hold)
        else $error("latched fault dropped without read");

    property p_page_set;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        page_set |=> st.page_rx;
    endproperty
    a_page_set: assert property (p_page_set)
        else $error("page received not latched");

    property p_page_read_clear;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (s_exp_accept and (AVS_READDATA_O[EXP_PAGE_RX] && !page_set)) |=> !st.page_rx;
    endproperty
    a_page_read_clear: assert property (p_page_read_clear)
        else $error("page received not cleared by read");

    property p_page_alt_clear;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (st.alt_np && (!LINK_I.mr_page_rx || st.tx_disable) && !page_set) |=> !st.page_rx;
    endproperty
    a_page_alt_clear: assert property (p_page_alt_clear)
        else $error("page received not cleared in alternate mode");

    property p_base_page;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (LINK_I.base_page_var && st.alt_np) |=> st.base_page ##1 (st.base_page || $past(exp_read));
    endproperty
    a_base_page: assert property (p_base_page)
        else $error("base page flag not latched");

    property p_exp_image;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_exp_wait ##1 s_exp_accept |->
            (AVS_READDATA_O[31:EXP_RSVD_LSB] == '0) && AVS_READDATA_O[EXP_NP_ABLE]
            && (AVS_READDATA_O[EXP_LP_AN_ABLE] == $past(LINK_I.partner_an_able))
            && (AVS_READDATA_O[EXP_LP_NP_ABLE] == $past(LINK_I.partner_np_able));
    endproperty
    a_exp_image: assert property (p_exp_image)
        else $error("expansion word image wrong");

    property p_top_bit;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (AVS_READ_I && !st.ack && (idx == IDX_PARTNER) && !LINK_I.base_page_rx)
        ##1 (AVS_READ_I && st.ack) |-> (AVS_READDATA_O[PA_NP_BIT] == st.ability[PA_NP_BIT]);
    endproperty
    a_top_bit: assert property (p_top_bit)
        else $error("partner next page bit read wrong");

    // Whole partner word as stored at the waiting edge
    property p_partner_image;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_part_wait ##1 s_read_accept |-> (AVS_READDATA_O == {REG_ZERO, $past(st.ability)});
    endproperty
    a_partner_image: assert property (p_partner_image)
        else $error("partner word read wrong");

    // Page flag kept while nothing clears it
    property p_page_hold;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (st.page_rx && !exp_read && !alt_clear) |=> st.page_rx;
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("page received dropped without read");

    // Page arriving during a read is not lost
    property p_page_unread_keep;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (exp_read && !AVS_READDATA_O[EXP_PAGE_RX] && st.page_rx && !alt_clear) |=> st.page_rx;
    endproperty
    a_page_unread_keep: assert property (p_page_unread_keep)
        else $error("unreported page received cleared");

    // Base page flag never set outside alternate mode
    property p_base_page_gate;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (!st.base_page && !(LINK_I.base_page_var && st.alt_np)) |=> !st.base_page;
    endproperty
    a_base_page_gate: assert property (p_base_page_gate)
        else $error("base page flag set without cause");

    // Alternate mode bit follows an accepted control write
    property p_alt_np_write;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (AVS_WRITE_I && st.ack && (idx == IDX_CONTROL) && AVS_BYTEENABLE_I[0])
        |=> (ALT_NP_O == $past(AVS_WRITEDATA_I[CTRL_ALT_NP]));
    endproperty
    a_alt_np_write: assert property (p_alt_np_write)
        else $error("alternate mode bit not written");

    // Strap defaults change only by software once loaded
    property p_adv_strap_hold;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (st.loaded && !(AVS_WRITE_I && st.ack && (idx == IDX_LOCAL_ADV))) |=> $stable(ADV_O);
    endproperty
    a_adv_strap_hold: assert property (p_adv_strap_hold)
        else $error("advertisement changed without write");

    property p_wait_bound;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (req && !st.ack) |=> (!AVS_WAITREQUEST_O || !req);
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("waitrequest held too long");

endmodule

// ### verification/anps_link_model.sv
// Purpose: Behavioural far end of the negotiation link for the status block
// Assumes: Same clock as the block; pages are one-cycle pulses
// Notes:   Released code word lines show the inverse of the last word

`timescale 1ns/100ps

module anps_link_model
    import anps_pkg::*;
(
    input  wire logic clk_i,
    output anps_link_s link_o
);
    // ****************************************************************
    // Link stimulus
    // ****************************************************************
    initial link_o = '0;

    // One page pulse, then the word lines are released
    task automatic send(input logic np, input logic [15:0] w);
        begin
            if (w[4:0] != SEL_IEEE8023 && w[4:0] != SEL_IEEE8029)
            begin
                w[4:0] = SEL_IEEE8023;
            end
            @(posedge clk_i);
            link_o.base_page_rx <= !np;
            link_o.next_page_rx <= np;
            link_o.code_word    <= w;
            @(posedge clk_i);
            link_o.base_page_rx <= 1'b0;
            link_o.next_page_rx <= 1'b0;
            link_o.code_word    <= ~w;
        end
    endtask

    // Level flags of the negotiation engine
    task automatic set_lv(input logic bpv, input logic pdf, input logic npa, input logic ana, input logic mpr);
        begin
            @(posedge clk_i);
            link_o.base_page_var   <= bpv;
            link_o.pd_fault        <= pdf;
            link_o.partner_np_able <= npa;
            link_o.partner_an_able <= ana;
            link_o.mr_page_rx      <= mpr;
        end
    endtask
endmodule

// ### verification/test_anps_status.sv
// Purpose: Self-checking bench of the partner ability status block
// Assumes: One wait cycle per bus access; strap pins static
// Notes:   Read results are checked from a queue by a monitor

`timescale 1ns/100ps

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_anps_status;
    import anps_pkg::*;

    logic        clk;
    logic        rstn;
    logic [7:0]  addr;
    logic        rd_req;
    logic        wr_req;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wreq;
    anps_link_s  link;
    logic        pause_pin;
    logic [3:0]  led_pins;
    anps_adv_s   adv;
    logic        alt_np;
    logic        tx_dis;
    logic [31:0] seed;
    logic [31:0] r;
    logic [15:0] w;
    logic [31:0] exp_q[$];
    logic [31:0] exp_w;
    logic [3:0]  be;
    int          fail_count;
    int          samples_checked;

    anps_status u_anps_status (.CLOCK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_req),
        .AVS_WRITE_I(wr_req), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .LINK_I(link), .PAUSE_CFG_PIN_I(pause_pin),
        .LED_CONFIG_PINS_I(led_pins), .ADV_O(adv), .ALT_NP_O(alt_np), .TX_DISABLE_O(tx_dis));

    anps_link_model u_anps_link_model (.clk_i(clk), .link_o(link));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Bus access; a read notes its expected word
    task automatic acc(input logic we, input logic [7:0] a, input logic [15:0] d);
        begin
            @(posedge clk);
            addr   <= a;
            wdata  <= {16'h0000, d};
            wr_req <= we;
            rd_req <= !we;
            if (!we)
            begin
                exp_q.push_back({16'h0000, d});
            end
            do
            begin
                @(posedge clk);
            end
            while (wreq !== 1'b0);
            rd_req <= 1'b0;
            wr_req <= 1'b0;
        end
    endtask

    task automatic give_verdict();
        if (exp_q.size() != 0)
            fail_count++;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Clock, monitor and watchdog
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare read data with the oldest note
    always @(posedge clk)
    begin
        if (rd_req === 1'b1 && wreq === 1'b0)
        begin
            exp_w = exp_q.pop_front();
            `CHK("readdata", exp_w, rdata)
        end
    end

    initial
    begin
        repeat (4000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        fail_count = 0;
        samples_checked = 0;
        seed = 32'h0dbe;
        rstn = 1'b0;
        addr = 8'h00;
        rd_req = 1'b0;
        wr_req = 1'b0;
        wdata = 32'h00000000;
        be = 4'hf;
        r = xs();
        pause_pin = r[0];
        led_pins = r[4:1];
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("adv", anps_adv_s'({pause_pin, led_pins}), adv)
        acc(1'b0, 8'h18, 16'h0004);
        acc(1'b0, 8'h3c, 16'h0000);
        acc(1'b0, 8'h10, {5'h00, pause_pin, 1'b0, led_pins, 5'h00});
        be <= 4'h1;
        acc(1'b1, 8'h10, 16'hffff);
        be <= 4'hf;
        @(posedge clk);
        `CHK("adv", anps_adv_s'({pause_pin, led_pins[3], 3'h7}), adv)
        $display("test defaults done");
        for (int i = 0; i < 6; i++)
        begin
            r = xs();
            w = {r[15:5], i[0] ? SEL_IEEE8029 : SEL_IEEE8023};
            u_anps_link_model.send(1'b0, w);
            acc(1'b0, 8'h14, w);
            acc(1'b0, 8'h18, 16'h0006);
            acc(1'b0, 8'h18, 16'h0004);
        end
        acc(1'b1, 8'h14, ~w);
        acc(1'b1, 8'h18, 16'hffff);
        acc(1'b0, 8'h14, w);
        acc(1'b0, 8'h18, 16'h0004);
        u_anps_link_model.send(1'b1, ~w);
        acc(1'b0, 8'h14, w);
        acc(1'b0, 8'h18, 16'h0006);
        fork
            u_anps_link_model.send(1'b0, w);
            acc(1'b0, 8'h18, 16'h0004);
        join
        acc(1'b0, 8'h18, 16'h0006);
        $display("test pages done");
        u_anps_link_model.set_lv(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        u_anps_link_model.set_lv(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        acc(1'b0, 8'h18, 16'h001d);
        acc(1'b0, 8'h18, 16'h000d);
        acc(1'b1, 8'h40, 16'h0002);
        @(posedge clk);
        `CHK("alt_np", 1'b1, alt_np)
        u_anps_link_model.set_lv(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        u_anps_link_model.set_lv(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        acc(1'b0, 8'h18, 16'h0024);
        acc(1'b0, 8'h18, 16'h0004);
        u_anps_link_model.send(1'b0, w);
        acc(1'b0, 8'h18, 16'h0006);
        u_anps_link_model.send(1'b0, w);
        u_anps_link_model.set_lv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        acc(1'b0, 8'h18, 16'h0004);
        u_anps_link_model.set_lv(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        acc(1'b1, 8'h40, 16'h2002);
        @(posedge clk);
        `CHK("tx_disable", 1'b1, tx_dis)
        u_anps_link_model.send(1'b0, w);
        acc(1'b0, 8'h18, 16'h0004);
        acc(1'b0, 8'h40, 16'h2002);
        $display("test alternate mode done");
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
